// >>> src/interrupt_trap_control.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module interrupt_trap_control (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire itc_pkg::apb_req_s apb_req,
  output itc_pkg::apb_rsp_s apb_rsp,
  // Core fetch side
  input wire itc_pkg::fetch_s fetch,
  output itc_pkg::trap_out_s trap_out,
  // External interrupt pins, active low
  input wire logic ext_irq_zero_n,
  input wire logic ext_irq_one_n,
  input wire logic ext_irq_two_n,
  // On-chip sources of level zero group
  input wire logic [1:0] dma_req,
  input wire logic [1:0] async_serial_channel_req,
  input wire logic [1:0] reload_timer_req,
  input wire logic csio_req,
  // Requests to the core, gated by enables; on-chip sources reach vector_req ungated
  output logic ext_irq_zero,
  output logic ext_irq_one,
  output logic ext_irq_two,
  output logic level_zero_req,
  output logic vector_req,
  output logic [7:0] vector,
  // Summary interrupt
  output logic irq
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0] vec_bits;
    logic trap_flag;
    logic fetch_byte_offset;
    logic [2:0] enables;
    logic [itc_pkg::num_events-1:0] status;
    logic [itc_pkg::num_events-1:0] mask;
    itc_pkg::trap_state_e st;
    logic [15:0] saved_pc;
    logic [31:0] rdata;
    logic [2:0] pin0;
    logic [2:0] pin1;
    logic vec_req_d;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;

  logic wr_en;
  logic rd_en;
  logic trap_hit;
  logic [2:0] pins;
  logic [itc_pkg::num_sources-1:0] src_req;
  logic any_src;
  logic [7:0] vec_w;
  logic [itc_pkg::num_events-1:0] ev;

  function automatic logic hit(input logic [31:0] a, input logic [11:0] r);
    hit = (a[11:0] == r) && (a[31:12] == 20'h00000);
  endfunction : hit

  // ==========================================================
  // Decode
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign trap_hit = fetch.undefined && (fetch.fetch_valid
    || fetch.ack_mode0) && (cur_ff.st == itc_pkg::st_idle);

  // Pins pass two flops before use, active low
  assign pins = ~cur_ff.pin1;
  assign ext_irq_zero = pins[0] && cur_ff.enables[itc_pkg::en0_bit];
  assign ext_irq_one = pins[1] && cur_ff.enables[itc_pkg::en1_bit];
  assign ext_irq_two = pins[2] && cur_ff.enables[itc_pkg::en2_bit];

  assign src_req = {csio_req, reload_timer_req, async_serial_channel_req,
    dma_req, ext_irq_two, ext_irq_one};

  vector_synth u_vec (
    .src_req(src_req),
    .vec_upper(cur_ff.vec_bits),
    .any_req(any_src),
    .vector(vec_w)
  );

  // Level zero group gated by bit 0
  assign level_zero_req = (|{csio_req, reload_timer_req,
    async_serial_channel_req, dma_req})
    && cur_ff.enables[itc_pkg::en0_bit];
  assign vector_req = any_src;
  assign vector = vec_w;

  assign ev[itc_pkg::ev_trap] = trap_hit;
  assign ev[itc_pkg::ev_vector] = any_src && !cur_ff.vec_req_d;
  assign irq = |(cur_ff.status & cur_ff.mask);

  // ==========================================================
  // Next state
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.pin0 = {ext_irq_two_n, ext_irq_one_n, ext_irq_zero_n};
    nxt_ff.pin1 = cur_ff.pin0;
    nxt_ff.vec_req_d = any_src;
    // Set wins over write-one-to-clear
    nxt_ff.status = cur_ff.status | ev;
    if (wr_en && hit(apb_req.paddr, itc_pkg::vector_low_addr)) begin
      nxt_ff.vec_bits = apb_req.pwdata[itc_pkg::vec_hi:itc_pkg::vec_lo];
    end
    if (wr_en && hit(apb_req.paddr, itc_pkg::int_trap_control_addr)) begin
      if (!apb_req.pwdata[itc_pkg::trap_bit]) begin
        nxt_ff.trap_flag = 1'b0;
      end
      nxt_ff.enables =
        apb_req.pwdata[itc_pkg::en2_bit:itc_pkg::en0_bit];
    end
    if (wr_en && hit(apb_req.paddr, itc_pkg::irq_status_addr)) begin
      nxt_ff.status = (cur_ff.status
        & ~apb_req.pwdata[itc_pkg::num_events-1:0]) | ev;
    end
    if (wr_en && hit(apb_req.paddr, itc_pkg::irq_mask_addr)) begin
      nxt_ff.mask = apb_req.pwdata[itc_pkg::num_events-1:0];
    end
    // Trap sequence: flag, push PC high then low, jump to restart
    case (cur_ff.st)
      itc_pkg::st_idle: begin
        if (trap_hit) begin
          nxt_ff.trap_flag = 1'b1;
          nxt_ff.fetch_byte_offset = fetch.second_byte_plus;
          nxt_ff.saved_pc = fetch.pc - itc_pkg::pc_step;
          nxt_ff.st = itc_pkg::st_push_hi;
        end
      end
      itc_pkg::st_push_hi: nxt_ff.st = itc_pkg::st_push_lo;
      itc_pkg::st_push_lo: nxt_ff.st = itc_pkg::st_jump;
      itc_pkg::st_jump: nxt_ff.st = itc_pkg::st_idle;
      default: nxt_ff.st = itc_pkg::st_idle;
    endcase
    // Read data captured in setup, held through access
    if (rd_en) begin
      nxt_ff.rdata = 32'h00000000;
      if (hit(apb_req.paddr, itc_pkg::vector_low_addr)) begin
        nxt_ff.rdata[7:0] = {cur_ff.vec_bits, itc_pkg::vec_low_bits_zero};
      end else if (hit(apb_req.paddr, itc_pkg::int_trap_control_addr)) begin
        nxt_ff.rdata[7:0] = {cur_ff.trap_flag, cur_ff.fetch_byte_offset,
          3'h0, cur_ff.enables};
      end else if (hit(apb_req.paddr, itc_pkg::irq_status_addr)) begin
        nxt_ff.rdata[itc_pkg::num_events-1:0] = cur_ff.status;
      end else if (hit(apb_req.paddr, itc_pkg::irq_mask_addr)) begin
        nxt_ff.rdata[itc_pkg::num_events-1:0] = cur_ff.mask;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cur_ff <= '0;
      cur_ff.vec_bits <= itc_pkg::vec_reset;
      cur_ff.trap_flag <= 1'b0;
      cur_ff.enables <= itc_pkg::enable_reset;
      cur_ff.st <= itc_pkg::st_idle;
      cur_ff.pin0 <= 3'h7;
      cur_ff.pin1 <= 3'h7;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    apb_rsp.prdata = cur_ff.rdata;
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = 1'b0;
    trap_out.trap_busy = cur_ff.st != itc_pkg::st_idle;
    trap_out.push_valid = (cur_ff.st == itc_pkg::st_push_hi)
      || (cur_ff.st == itc_pkg::st_push_lo);
    trap_out.push_data = (cur_ff.st == itc_pkg::st_push_hi)
      ? cur_ff.saved_pc[15:8] : cur_ff.saved_pc[7:0];
    trap_out.jump_valid = cur_ff.st == itc_pkg::st_jump;
    trap_out.jump_addr = itc_pkg::restart_address;
  end

  // ==========================================================
  // Checks: trap flag and trap sequence
  a_trap_sets_flag: assert property (
    @(posedge clk) disable iff (!nrst)
    trap_hit |=> cur_ff.trap_flag)
    else $error("trap flag not set");
  a_flag_no_sw_set: assert property (
    @(posedge clk) disable iff (!nrst)
    !cur_ff.trap_flag && !trap_hit |=> !cur_ff.trap_flag)
    else $error("trap flag set without trap");
  // A trap in the same cycle wins, so it is left out here
  a_flag_clear: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_en && hit(apb_req.paddr, itc_pkg::int_trap_control_addr)
    && !apb_req.pwdata[itc_pkg::trap_bit] && !trap_hit
    |=> !cur_ff.trap_flag)
    else $error("trap flag not cleared");
  a_offset_capture: assert property (
    @(posedge clk) disable iff (!nrst)
    trap_hit |=> cur_ff.fetch_byte_offset == $past(fetch.second_byte_plus))
    else $error("offset bit not captured");
  a_offset_ro: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_en && hit(apb_req.paddr, itc_pkg::int_trap_control_addr)
    && !trap_hit |=> $stable(cur_ff.fetch_byte_offset))
    else $error("offset bit written by software");
  a_trap_sequence: assert property (
    @(posedge clk) disable iff (!nrst)
    trap_hit |=> trap_out.push_valid ##1 trap_out.push_valid
    ##1 trap_out.jump_valid
    && trap_out.jump_addr == itc_pkg::restart_address)
    else $error("trap sequence wrong");
  a_saved_pc: assert property (
    @(posedge clk) disable iff (!nrst)
    trap_hit |=> cur_ff.saved_pc == $past(fetch.pc) - itc_pkg::pc_step)
    else $error("saved pc wrong");
  a_push_bytes: assert property (
    @(posedge clk) disable iff (!nrst)
    trap_out.push_valid && !$past(trap_out.push_valid)
    |-> trap_out.push_data == cur_ff.saved_pc[15:8])
    else $error("high pc byte not pushed first");

  // ==========================================================
  // Checks: reset values
  a_reset_values: assert property (
    @(posedge clk)
    $rose(nrst) |-> cur_ff.enables == itc_pkg::enable_reset
    && !cur_ff.trap_flag && cur_ff.vec_bits == itc_pkg::vec_reset)
    else $error("bad reset values");
  a_flag_reset: assert property (
    @(posedge clk)
    !nrst |=> !cur_ff.trap_flag)
    else $error("trap flag survives reset");
  a_vec_reset: assert property (
    @(posedge clk)
    !nrst |=> cur_ff.vec_bits == itc_pkg::vec_reset)
    else $error("vector bits survive reset");
  a_enable_reset: assert property (
    @(posedge clk)
    !nrst |=> cur_ff.enables == itc_pkg::enable_reset)
    else $error("enables not reset");

  // ==========================================================
  // Checks: registers, gating and vector
  a_vec_write: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_en && hit(apb_req.paddr, itc_pkg::vector_low_addr)
    |=> cur_ff.vec_bits
    == $past(apb_req.pwdata[itc_pkg::vec_hi:itc_pkg::vec_lo]))
    else $error("vector bits not written");
  a_enable_write: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_en && hit(apb_req.paddr, itc_pkg::int_trap_control_addr)
    |=> cur_ff.enables
    == $past(apb_req.pwdata[itc_pkg::en2_bit:itc_pkg::en0_bit]))
    else $error("enables not written");
  a_unused_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    rd_en && hit(apb_req.paddr, itc_pkg::int_trap_control_addr)
    |=> cur_ff.rdata[5:3] == 3'h0)
    else $error("unused bits not zero");
  a_gate_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    level_zero_req |-> cur_ff.enables[itc_pkg::en0_bit])
    else $error("level zero gating wrong");
  a_gate_pin_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    ext_irq_zero |-> cur_ff.enables[itc_pkg::en0_bit])
    else $error("ext zero gating wrong");
  // Two cycles back is the pin level the synchroniser now shows
  a_gate_one: assert property (
    @(posedge clk) disable iff (!nrst)
    ext_irq_one |-> cur_ff.enables[itc_pkg::en1_bit]
    && !$past(ext_irq_one_n, 2))
    else $error("ext one gating wrong");
  a_gate_two: assert property (
    @(posedge clk) disable iff (!nrst)
    ext_irq_two |-> cur_ff.enables[itc_pkg::en2_bit])
    else $error("ext two gating wrong");
  a_vector_upper: assert property (
    @(posedge clk) disable iff (!nrst)
    vector_req
    |-> vector[itc_pkg::vec_hi:itc_pkg::vec_lo] == cur_ff.vec_bits)
    else $error("vector upper bits wrong");

  // ==========================================================
  // Cover points
  c_trap: cover property (@(posedge clk) disable iff (!nrst)
    trap_hit && fetch.ack_mode0);
  c_irq: cover property (@(posedge clk) disable iff (!nrst) irq);
  c_clear: cover property (@(posedge clk) disable iff (!nrst)
    cur_ff.trap_flag ##1 !cur_ff.trap_flag);
  c_reset_after_trap: cover property (@(posedge clk)
    cur_ff.trap_flag ##1 !nrst);
  c_vector_two: cover property (@(posedge clk) disable iff (!nrst)
    vector_req && vector[4:1] == 4'h1);
endmodule : interrupt_trap_control

// >>> src/itc_pkg.sv
package itc_pkg;
  // ==========================================================
  // Register map
  // Printed offset 0x33 is not a multiple of four, so the offsets
  // are register indices and the byte address is four times
  localparam logic [7:0] vector_low_idx = 8'h33;
  localparam logic [7:0] int_trap_control_idx = 8'h34;
  localparam logic [7:0] irq_status_idx = 8'h35;
  localparam logic [7:0] irq_mask_idx = 8'h36;
  localparam logic [11:0] vector_low_addr = {2'h0, vector_low_idx, 2'h0};
  localparam logic [11:0] int_trap_control_addr =
    {2'h0, int_trap_control_idx, 2'h0};
  localparam logic [11:0] irq_status_addr = {2'h0, irq_status_idx, 2'h0};
  localparam logic [11:0] irq_mask_addr = {2'h0, irq_mask_idx, 2'h0};

  // ==========================================================
  // Field positions and reset values
  localparam int trap_bit = 7;
  localparam int offset_bit = 6;
  localparam int en2_bit = 2;
  localparam int en1_bit = 1;
  localparam int en0_bit = 0;
  localparam int vec_hi = 7;
  localparam int vec_lo = 5;
  localparam logic [2:0] vec_reset = 3'h0;
  localparam logic [2:0] enable_reset = 3'h1;
  localparam logic [4:0] vec_low_bits_zero = 5'h00;
  localparam logic [15:0] restart_address = 16'h0000;
  localparam logic [15:0] pc_step = 16'h0001;

  // Interrupt status bits: trap taken, vectored request seen
  localparam int ev_trap = 0;
  localparam int ev_vector = 1;
  localparam int num_events = 2;

  // Source numbering for the vector: bits 4..1 of the vector
  localparam int num_sources = 9;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_push_hi = 2'b01,
    st_push_lo = 2'b10,
    st_jump = 2'b11
  } trap_state_e;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic fetch_valid;
    logic ack_mode0;
    logic undefined;
    logic second_byte_plus;
    logic [15:0] pc;
  } fetch_s;

  typedef struct packed {
    logic push_valid;
    logic [7:0] push_data;
    logic jump_valid;
    logic [15:0] jump_addr;
    logic trap_busy;
  } trap_out_s;
endpackage : itc_pkg

// >>> src/vector_synth.sv
`timescale 1ns/1ps
// Priority pick of sources (pins one and two, then on-chip) and vector forming.
module vector_synth (
  // Sources, index 0 is highest priority
  input wire logic [itc_pkg::num_sources-1:0] src_req,
  // Upper vector bits
  input wire logic [2:0] vec_upper,
  // Result
  output logic any_req,
  output logic [7:0] vector
);
  logic [3:0] pick;

  always_comb begin
    pick = 4'h0;
    any_req = 1'b0;
    for (int i = itc_pkg::num_sources - 1; i >= 0; i--) begin
      if (src_req[i]) begin
        pick = 4'(i);
        any_req = 1'b1;
      end
    end
    vector = {vec_upper, pick, 1'b0};
  end
endmodule : vector_synth

// >>> tb/core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Core side: issues fetches, collects the trap push and jump
module core_model (
  // Clock
  input wire logic clk,
  // Trap side of the block
  input wire itc_pkg::trap_out_s trap_out,
  output itc_pkg::fetch_s fetch,
  // Observed trap outcome
  output logic [15:0] saved_pc,
  output logic [7:0] jumps
);
  initial begin
    fetch = '0;
    saved_pc = 16'h0000;
    jumps = 8'h00;
  end

  always @(posedge clk) begin
    if (trap_out.push_valid === 1'b1) begin
      saved_pc <= {saved_pc[7:0], trap_out.push_data};
    end
    if (trap_out.jump_valid === 1'b1 && trap_out.jump_addr === 16'h0000) begin
      jumps <= jumps + 8'h01;
    end
  end

  task automatic issue(input logic ack, input logic undef, input logic plus,
                       input logic [15:0] pc);
    @(posedge clk);
    fetch.fetch_valid <= !ack;
    fetch.ack_mode0 <= ack;
    fetch.undefined <= undef;
    fetch.second_byte_plus <= plus;
    fetch.pc <= pc;
    @(posedge clk);
    fetch.fetch_valid <= 1'b0;
    fetch.ack_mode0 <= 1'b0;
    // Released lines do not keep their last value
    fetch.undefined <= ~undef;
    fetch.second_byte_plus <= ~plus;
    fetch.pc <= ~pc;
  endtask : issue
endmodule : core_model

// >>> tb/test_interrupt_trap_control.sv
`timescale 1ns/1ps
`define CHK(n, g, e) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module test_interrupt_trap_control;
  localparam logic [11:0] vl = itc_pkg::vector_low_addr;
  localparam logic [11:0] tc = itc_pkg::int_trap_control_addr;
  localparam logic [11:0] st = itc_pkg::irq_status_addr;
  localparam logic [11:0] mk = itc_pkg::irq_mask_addr;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  itc_pkg::apb_req_s req = '0;
  itc_pkg::apb_rsp_s rsp;
  itc_pkg::fetch_s fetch;
  itc_pkg::trap_out_s tout;
  logic [2:0] pin_n = 3'h7;
  logic [1:0] dma = 2'h0;
  logic [1:0] asc = 2'h0;
  logic [1:0] tmr = 2'h0;
  logic csio = 1'b0;
  logic e0, e1, e2, lz, vreq, irq;
  logic [7:0] vec, jumps;
  logic [15:0] saved, pc;
  logic [31:0] rnd = 32'h6aff79e9;
  logic [31:0] expv;
  logic [31:0] q[$];
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  interrupt_trap_control uut (.clk(clk), .nrst(nrst), .apb_req(req),
    .apb_rsp(rsp), .fetch(fetch), .trap_out(tout), .ext_irq_zero_n(pin_n[0]),
    .ext_irq_one_n(pin_n[1]), .ext_irq_two_n(pin_n[2]), .dma_req(dma),
    .async_serial_channel_req(asc), .reload_timer_req(tmr), .csio_req(csio),
    .ext_irq_zero(e0), .ext_irq_one(e1), .ext_irq_two(e2),
    .level_zero_req(lz), .vector_req(vreq), .vector(vec), .irq(irq));
  core_model model (.clk(clk), .trap_out(tout), .fetch(fetch),
    .saved_pc(saved), .jumps(jumps));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.paddr <= {20'h00000, a};
    req.pwrite <= w;
    req.pwdata <= d;
    req.psel <= 1'b1;
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) @(posedge clk);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    q.push_back({24'h000000, e});
    apb(1'b0, a, 32'h00000000);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task finish_test;
    $display("Comparisons %0d errors %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // Read data checked at the edge that completes the access
  always @(posedge clk) begin
    cycles++;
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
      expv = q.pop_front();
      `CHK("prdata", rsp.prdata, expv)
    end
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(vl, 8'h00);
    rd(tc, 8'h01);
    rd(12'hffc, 8'h00);
    apb(1'b1, tc, 32'h000000ff);
    rd(tc, 8'h07);
    pin_n <= 3'h0;
    csio <= 1'b1;
    rnd = lfsr(rnd);
    apb(1'b1, vl, rnd);
    rd(vl, {rnd[7:5], 5'h00});
    settle();
    `CHK("gates", {e2, e1, e0, lz}, 4'hf)
    `CHK("vector", {vreq, vec}, {1'b1, rnd[7:5], 5'h00})
    apb(1'b1, tc, 32'h00000004);
    settle();
    `CHK("gates", {e2, e1, e0, lz}, 4'h8)
    `CHK("vector", vec, {rnd[7:5], 4'h1, 1'b0})
    apb(1'b1, tc, 32'h00000000);
    dma <= 2'h2;
    settle();
    `CHK("gates", {e2, e1, e0, lz}, 4'h0)
    `CHK("vector", {vreq, vec}, {1'b1, rnd[7:5], 4'h3, 1'b0})
    rnd = lfsr(rnd);
    pc = rnd[15:0] | 16'h0002;
    model.issue(1'b0, 1'b0, 1'b0, pc);
    rd(tc, 8'h00);
    model.issue(1'b0, 1'b1, 1'b1, pc);
    settle();
    `CHK("saved", saved, pc - 16'h0001)
    rd(tc, 8'hc0);
    apb(1'b1, tc, 32'h00000000);
    model.issue(1'b1, 1'b1, 1'b0, ~pc);
    settle();
    `CHK("saved", saved, ~pc - 16'h0001)
    `CHK("jumps", jumps, 8'h02)
    rd(tc, 8'h80);
    apb(1'b1, tc, 32'h00000000);
    rd(tc, 8'h00);
    rd(st, 8'h03);
    `CHK("irq", irq, 1'b0)
    apb(1'b1, mk, 32'h00000001);
    settle();
    `CHK("irq", irq, 1'b1)
    apb(1'b1, st, 32'h00000001);
    settle();
    `CHK("irq", irq, 1'b0)
    rd(st, 8'h02);
    model.issue(1'b0, 1'b1, 1'b0, pc);
    settle();
    `CHK("jumps", jumps, 8'h03)
    rd(tc, 8'h80);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(tc, 8'h01);
    rd(vl, 8'h00);
    settle();
    finish_test();
  end
endmodule : test_interrupt_trap_control
